// File: include/rap_pkg.sv
// Constants and types for the reset and alarm pin control block
//
// Overview of operation
// - Hardware reset pin low returns every flip-flop of the block to its initial state.
// - Hardware reset loads every configuration register with its default value.
// - Clock output enables stay low, outputs tristated, while hardware reset is held.
// - Shared pin is the interrupt output when interrupt pin select is 1.
// - In interrupt mode the asserted level follows the interrupt polarity bit.
// - Shared pin shows input one loss/offset when its enable is 1, select 0.
// - At default polarity alarm pin is 0 with clock present, 1 on fault.
// - Input one alarm level is set by the common alarm polarity bit.
// - Shared pin tristates when neither interrupt nor input one alarm is selected.
// - Second pin reports input two loss/offset when enabled, else tristates.
// - Input two alarm level inverts when the common alarm polarity bit is set.
// - Loss select: 00 off, 10 slow detector, 11 normal detector, 01 reserved.
// - Offset enable bit turns frequency offset monitoring off (0) or on (1).
package rap_pkg;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFF   = 8'h00;
	localparam logic [7:0] MON_OFF    = 8'h04;
	localparam logic [7:0] LIVE_OFF   = 8'h08;
	localparam logic [7:0] STAT_OFF   = 8'h0C;
	localparam logic [7:0] CLEAR_OFF  = 8'h10;
	localparam logic [7:0] ENABLE_OFF = 8'h14;

	// Values after reset
	localparam logic [5:0] CTRL_RST   = 6'h02;
	localparam logic [5:0] MON_RST    = 6'h3F;
	localparam logic [3:0] ENABLE_RST = 4'h0;
	localparam int         SYNC_STAGES = 2;

	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Loss monitor select codes
	typedef enum logic [1:0] {
		LOSS_OFF    = 2'h0,
		LOSS_RSVD   = 2'h1,
		LOSS_SLOW   = 2'h2,
		LOSS_NORMAL = 2'h3
	} rap_loss_sel_t;

	// Control register: pin functions, polarities, output enable
	typedef struct packed {
		logic out_enable;
		logic alarm_polarity;
		logic input2_alarm_pin_enable;
		logic input1_alarm_pin_enable;
		logic irq_polarity;
		logic irq_pin_select;
	} rap_ctrl_t;

	// Monitor register: per-input loss select and offset enable
	typedef struct packed {
		logic [1:0][1:0] loss_sel;
		logic [1:0]      offset_en;
	} rap_mon_t;

	// Raw detector flags of one clock input
	typedef struct packed {
		logic offset;
		logic normal_loss;
		logic slow_loss;
	} rap_det_t;

	// Whole state of the block
	typedef struct packed {
		rap_ctrl_t       ctrl;
		rap_mon_t        mon;
		logic [3:0]      int_status;
		logic [3:0]      int_enable;
		rap_det_t [1:0]  sync1;
		rap_det_t [1:0]  sync2;
		logic            aw_have;
		logic [7:0]      awaddr;
		logic            w_have;
		logic [7:0]      wdata;
		logic            wstrb0;
		logic            bvalid;
		logic [1:0]      bresp;
		logic            rvalid;
		logic [1:0]      rresp;
		logic [7:0]      rdata;
		logic            pin1_out;
		logic            pin1_oe;
		logic            pin2_out;
		logic            pin2_oe;
		logic [1:0]      clk_oe;
	} rap_state_t;

endpackage

// File: core/rap_pin_ctrl.sv
// Reset, interrupt and clock-input alarm pin logic with AXI4-Lite registers
`timescale 1ns/1ps
module rap_pin_ctrl (
	// Clock and resets
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic                hw_reset_n,
	// Detector flags of clock_input_one and clock_input_two
	input  wire rap_pkg::rap_det_t   det_in1,
	input  wire rap_pkg::rap_det_t   det_in2,
	// Pins
	output logic                     irq_or_input1_alarm_pin_out,
	output logic                     irq_or_input1_alarm_pin_oe,
	output logic                     input2_alarm_pin_out,
	output logic                     input2_alarm_pin_oe,
	output logic [1:0]               clk_out_oe,
	output logic                     irq,
	// AXI4-Lite write address
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [7:0]          s_axi_awaddr,
	// AXI4-Lite write data
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	// AXI4-Lite write response
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	output logic [1:0]               s_axi_bresp,
	// AXI4-Lite read
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	input  wire logic [7:0]          s_axi_araddr,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp
);

	rap_pkg::rap_state_t  st_reg;
	rap_pkg::rap_state_t  st_next;
	logic [1:0]           hw_rst_pipe_reg;
	logic                 core_rst;
	logic [1:0]           loss_act;
	logic [1:0]           off_act;
	logic [1:0]           bad;
	logic [3:0]           evt;
	logic                 irq_lvl;
	logic                 wr_fire;
	logic                 rd_fire;

	////////////////////////////////////////////////////////////////////////
	// Reset synchroniser: asserts at once, releases after two edges

	always_ff @(posedge clk or posedge rst or negedge hw_reset_n) begin
		if (rst || !hw_reset_n) begin
			hw_rst_pipe_reg <= 2'h3;
		end else begin
			hw_rst_pipe_reg <= {hw_rst_pipe_reg[0], 1'b0};
		end
	end

	assign core_rst = hw_rst_pipe_reg[1];

	////////////////////////////////////////////////////////////////////////
	// Per-input alarm conditions

	generate
		for (genvar i = 0; i < 2; i++) begin : g_mon
			always_comb begin
				case (rap_pkg::rap_loss_sel_t'(st_reg.mon.loss_sel[i]))
					rap_pkg::LOSS_SLOW: begin
						loss_act[i] = st_reg.sync2[i].slow_loss;
					end
					rap_pkg::LOSS_NORMAL: begin
						loss_act[i] = st_reg.sync2[i].normal_loss;
					end
					default: begin
						// Off and the reserved code monitor nothing
						loss_act[i] = 1'b0;
					end
				endcase
				off_act[i] = st_reg.mon.offset_en[i] & st_reg.sync2[i].offset;
				bad[i] = loss_act[i] | off_act[i];
			end
		end
	endgenerate

	assign evt = {off_act[1], loss_act[1], off_act[0], loss_act[0]};
	assign irq_lvl = |(st_reg.int_status & st_reg.int_enable);

	////////////////////////////////////////////////////////////////////////
	// Bus handshakes

	assign s_axi_awready = !st_reg.aw_have && !st_reg.bvalid;
	assign s_axi_wready  = !st_reg.w_have && !st_reg.bvalid;
	assign s_axi_arready = !st_reg.rvalid;
	assign wr_fire       = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
	assign rd_fire       = s_axi_arvalid && s_axi_arready;

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		st_next = st_reg;

		// Two-stage capture of the detector flags
		st_next.sync1 = {det_in2, det_in1};
		st_next.sync2 = st_reg.sync1;

		// Write address and data are taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			st_next.aw_have = 1'b1;
			st_next.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_next.w_have = 1'b1;
			st_next.wdata  = s_axi_wdata[7:0];
			st_next.wstrb0 = s_axi_wstrb[0];
		end

		// Sticky bits clear on a write of one to the clear register
		if (wr_fire && st_reg.awaddr == rap_pkg::CLEAR_OFF && st_reg.wstrb0) begin
			st_next.int_status = st_reg.int_status & ~st_reg.wdata[3:0];
		end
		// A live alarm re-sets its bit, winning over a clear
		st_next.int_status = st_next.int_status | evt;

		if (wr_fire) begin
			st_next.aw_have = 1'b0;
			st_next.w_have  = 1'b0;
			st_next.bvalid  = 1'b1;
			st_next.bresp   = rap_pkg::RESP_OKAY;
			case (st_reg.awaddr)
				rap_pkg::CTRL_OFF: begin
					if (st_reg.wstrb0) begin
						st_next.ctrl = rap_pkg::rap_ctrl_t'(st_reg.wdata[5:0]);
					end
				end
				rap_pkg::MON_OFF: begin
					if (st_reg.wstrb0) begin
						st_next.mon = rap_pkg::rap_mon_t'(st_reg.wdata[5:0]);
					end
				end
				rap_pkg::ENABLE_OFF: begin
					if (st_reg.wstrb0) begin
						st_next.int_enable = st_reg.wdata[3:0];
					end
				end
				rap_pkg::CLEAR_OFF, rap_pkg::LIVE_OFF, rap_pkg::STAT_OFF: begin
					// Live and status registers ignore writes; the clear register acts above
					st_next.bresp = rap_pkg::RESP_OKAY;
				end
				default: begin
					st_next.bresp = rap_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end

		// Read answer is registered on the same edge that takes the address
		if (rd_fire) begin
			st_next.rvalid = 1'b1;
			st_next.rresp  = rap_pkg::RESP_OKAY;
			case (s_axi_araddr)
				rap_pkg::CTRL_OFF: begin
					st_next.rdata = {2'h0, st_reg.ctrl};
				end
				rap_pkg::MON_OFF: begin
					st_next.rdata = {2'h0, st_reg.mon};
				end
				rap_pkg::LIVE_OFF: begin
					st_next.rdata = {4'h0, evt};
				end
				rap_pkg::STAT_OFF: begin
					st_next.rdata = {4'h0, st_reg.int_status};
				end
				rap_pkg::ENABLE_OFF: begin
					st_next.rdata = {4'h0, st_reg.int_enable};
				end
				rap_pkg::CLEAR_OFF: begin
					st_next.rdata = 8'h00;
				end
				default: begin
					st_next.rdata = 8'h00;
					st_next.rresp = rap_pkg::RESP_SLVERR;
				end
			endcase
		end else if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end

		// Shared pin: interrupt has priority over the input one alarm
		if (st_reg.ctrl.irq_pin_select) begin
			st_next.pin1_oe  = 1'b1;
			st_next.pin1_out = irq_lvl ~^ st_reg.ctrl.irq_polarity;
		end else if (st_reg.ctrl.input1_alarm_pin_enable) begin
			st_next.pin1_oe  = 1'b1;
			st_next.pin1_out = bad[0] ^ st_reg.ctrl.alarm_polarity;
		end else begin
			st_next.pin1_oe  = 1'b0;
			st_next.pin1_out = 1'b0;
		end

		st_next.pin2_oe  = st_reg.ctrl.input2_alarm_pin_enable;
		st_next.pin2_out = st_reg.ctrl.input2_alarm_pin_enable
			& (bad[1] ^ st_reg.ctrl.alarm_polarity);

		// Clock outputs stay off until software enables them
		st_next.clk_oe = {2{st_reg.ctrl.out_enable}};
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk or posedge core_rst) begin
		if (core_rst) begin
			st_reg            <= '0;
			st_reg.ctrl       <= rap_pkg::rap_ctrl_t'(rap_pkg::CTRL_RST);
			st_reg.mon        <= rap_pkg::rap_mon_t'(rap_pkg::MON_RST);
			st_reg.int_enable <= rap_pkg::ENABLE_RST;
			st_reg.clk_oe     <= 2'h0;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign irq_or_input1_alarm_pin_out = st_reg.pin1_out;
	assign irq_or_input1_alarm_pin_oe  = st_reg.pin1_oe;
	assign input2_alarm_pin_out        = st_reg.pin2_out;
	assign input2_alarm_pin_oe         = st_reg.pin2_oe;
	assign clk_out_oe                  = st_reg.clk_oe & {2{!core_rst}};
	assign irq                         = irq_lvl;
	assign s_axi_bvalid                = st_reg.bvalid;
	assign s_axi_bresp                 = st_reg.bresp;
	assign s_axi_rvalid                = st_reg.rvalid;
	assign s_axi_rdata                 = {24'h000000, st_reg.rdata};
	assign s_axi_rresp                 = st_reg.rresp;

endmodule

// File: bench/rap_pin_ctrl_assertions.sv
// Checker of reset, pin and bus timing for the pin control block
`timescale 1ns/1ps
module rap_pin_ctrl_checker (
	// Clock and resets
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        hw_reset_n,
	// Pins
	input wire logic        irq_or_input1_alarm_pin_oe,
	input wire logic        input2_alarm_pin_oe,
	input wire logic [1:0]  clk_out_oe,
	input wire logic        irq,
	// Bus
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst || !hw_reset_n);
	property p_hw_tri;
		disable iff (rst) !hw_reset_n |-> clk_out_oe == 2'h0 &&
			!irq_or_input1_alarm_pin_oe && !input2_alarm_pin_oe;
	endproperty
	a_hw_tri: assert property (p_hw_tri) else $error("pins driven");
	property p_hw_irq;
		disable iff (rst) !hw_reset_n |-> !irq;
	endproperty
	a_hw_irq: assert property (p_hw_irq) else $error("irq in reset");
	property p_rel;
		disable iff (rst) $rose(hw_reset_n) |-> !clk_out_oe[0] ##1 !clk_out_oe[0];
	endproperty
	a_rel: assert property (p_rel) else $error("early clock");
	property p_b_drop;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_drop: assert property (p_b_drop) else $error("bvalid stuck");
	property p_ar_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_ar_answer: assert property (p_ar_answer) else $error("no read data");
	property p_r_upper;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
	endproperty
	a_r_upper: assert property (p_r_upper) else $error("upper bits set");
	property p_irq_fall;
		$fell(irq) |-> s_axi_bvalid || $past(s_axi_wvalid);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq lost");
	property p_pin_quiet;
		$changed(irq_or_input1_alarm_pin_oe) |->
			$past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3);
	endproperty
	a_pin_quiet: assert property (p_pin_quiet) else $error("oe moved");
	c_irq: cover property ($rose(irq));
	c_pin2: cover property ($rose(input2_alarm_pin_oe));
	c_err: cover property (s_axi_bvalid && s_axi_bresp == rap_pkg::RESP_SLVERR);
endmodule

bind rap_pin_ctrl rap_pin_ctrl_checker u_chk (.clk, .rst, .hw_reset_n,
	.irq_or_input1_alarm_pin_oe, .input2_alarm_pin_oe, .clk_out_oe, .irq,
	.s_axi_wvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata);

// File: bench/rap_host_model.sv
// Host-side model: drives the reset pin and reads the alarm lines
`timescale 1ns/1ps
module rap_host_model (
	input  wire logic clk,
	input  wire logic rst_req,
	input  wire logic pin1_out,
	input  wire logic pin1_oe,
	input  wire logic pin2_out,
	input  wire logic pin2_oe,
	output logic      hw_reset_n,
	output logic      pin1_lvl,
	output logic      pin2_lvl
);
	logic pin1_last;
	logic pin2_last;
	// Reset on request; host reprograms before expecting clocks
	assign hw_reset_n = !rst_req;
	// A released line shows the inverse of its last driven level
	always_ff @(posedge clk) begin
		if (pin1_oe) pin1_last <= pin1_out;
		if (pin2_oe) pin2_last <= pin2_out;
	end
	assign pin1_lvl = pin1_oe ? pin1_out : !pin1_last;
	assign pin2_lvl = pin2_oe ? pin2_out : !pin2_last;
endmodule

// File: bench/tb.sv
// Self-checking bench of the pin control block
`timescale 1ns/1ps
module tb;
	logic clk, rst, rst_req, hw_reset_n, irq, p1_lvl, p2_lvl;
	logic irq_or_input1_alarm_pin_out, irq_or_input1_alarm_pin_oe;
	logic input2_alarm_pin_out, input2_alarm_pin_oe;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [1:0] clk_out_oe, s_axi_bresp, s_axi_rresp;
	logic [3:0] s_axi_wstrb;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	rap_pkg::rap_det_t det_in1, det_in2;
	int err_total, tests_run, cyc;
	rap_pin_ctrl dut (.clk, .rst, .hw_reset_n, .det_in1, .det_in2,
		.irq_or_input1_alarm_pin_out, .irq_or_input1_alarm_pin_oe,
		.input2_alarm_pin_out, .input2_alarm_pin_oe, .clk_out_oe, .irq,
		.s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
		.s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
		.s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
		.s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
	rap_host_model host (.clk, .rst_req, .hw_reset_n,
		.pin1_out(irq_or_input1_alarm_pin_out), .pin1_oe(irq_or_input1_alarm_pin_oe),
		.pin2_out(input2_alarm_pin_out), .pin2_oe(input2_alarm_pin_oe),
		.pin1_lvl(p1_lvl), .pin2_lvl(p2_lvl));
	always #50 clk = !clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			end_sim();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task end_sim;
		$display("errors %0d checks %0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Write returns bresp, read returns rdata with rresp in bits 31:30
	task automatic xfer(input bit w, input logic [7:0] a,
			input logic [31:0] d, input logic [31:0] e);
		bit ha, hv, hb;
		logic [31:0] q;
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		// Waits for the answer; only the bench timeout ends a hang
		while (!hb) begin
			@(negedge clk);
			ha = s_axi_awvalid & s_axi_awready | s_axi_arvalid & s_axi_arready;
			hv = s_axi_wvalid & s_axi_wready;
			hb = s_axi_bready & s_axi_bvalid | s_axi_rready & s_axi_rvalid;
			q = w ? {30'h0, s_axi_bresp} : s_axi_rdata | {s_axi_rresp, 30'h0};
			@(posedge clk);
			s_axi_awvalid <= s_axi_awvalid & !ha;
			s_axi_arvalid <= s_axi_arvalid & !ha;
			s_axi_wvalid <= s_axi_wvalid & !hv;
		end
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		chk(q, e);
		// One idle edge, so a following call never reassigns a strobe at once
		@(posedge clk);
	endtask
	// Pin vector: irq, clock enables, then enable and level of each pin
	task pk(input logic [31:0] e);
		@(negedge clk);
		chk({25'h0, irq, clk_out_oe, irq_or_input1_alarm_pin_oe,
			irq_or_input1_alarm_pin_oe & p1_lvl, input2_alarm_pin_oe,
			input2_alarm_pin_oe & p2_lvl}, e);
		@(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////////////
	task t_def;
		xfer(1'b0, rap_pkg::CTRL_OFF, 32'h0, 32'h2);
		xfer(1'b0, rap_pkg::MON_OFF, 32'h0, 32'h3F);
		xfer(1'b1, 8'h40, 32'hFF, {30'h0, rap_pkg::RESP_SLVERR});
		xfer(1'b0, 8'h40, 32'h0, {rap_pkg::RESP_SLVERR, 30'h0});
		// A write without byte lane zero must leave the register alone
		s_axi_wstrb <= 4'h0;
		xfer(1'b1, rap_pkg::CTRL_OFF, 32'h3F, 32'h0);
		s_axi_wstrb <= 4'hF;
		xfer(1'b0, rap_pkg::CTRL_OFF, 32'h0, 32'h2);
		pk(32'h0);
	endtask
	task t_hw;
		xfer(1'b1, rap_pkg::CTRL_OFF, 32'h20, 32'h0);
		xfer(1'b1, rap_pkg::ENABLE_OFF, 32'hF, 32'h0);
		pk(32'h30);
		rst_req <= 1'b1;
		repeat (2) @(posedge clk);
		pk(32'h0);
		rst_req <= 1'b0;
		repeat (4) @(posedge clk);
		xfer(1'b0, rap_pkg::CTRL_OFF, 32'h0, 32'h2);
		xfer(1'b0, rap_pkg::ENABLE_OFF, 32'h0, 32'h0);
	endtask
	task t_a1;
		int c, p;
		xfer(1'b1, rap_pkg::CTRL_OFF, 32'h4, 32'h0);
		for (c = 0; c < 4; c++) begin
			xfer(1'b1, rap_pkg::MON_OFF, 32'h30 | 32'(c) << 2, 32'h0);
			for (p = 1; p < 3; p++) begin
				det_in1 <= 3'(p);
				repeat (4) @(posedge clk);
				pk((c == 2 && p == 1 || c == 3 && p == 2) ? 32'hC : 32'h8);
				det_in1 <= 3'h0;
				repeat (4) @(posedge clk);
			end
		end
		xfer(1'b1, rap_pkg::MON_OFF, 32'h1, 32'h0);
		det_in1 <= 3'h4;
		repeat (4) @(posedge clk);
		pk(32'hC);
		xfer(1'b1, rap_pkg::MON_OFF, 32'h0, 32'h0);
		pk(32'h8);
		xfer(1'b1, rap_pkg::MON_OFF, 32'h3F, 32'h0);
		det_in1 <= 3'h2;
		repeat (4) @(posedge clk);
		pk(32'hC);
		xfer(1'b0, rap_pkg::LIVE_OFF, 32'h0, 32'h1);
		xfer(1'b1, rap_pkg::CTRL_OFF, 32'h14, 32'h0);
		pk(32'h8);
		det_in1 <= 3'h0;
		repeat (4) @(posedge clk);
		pk(32'hC);
		xfer(1'b0, rap_pkg::STAT_OFF, 32'h0, 32'h3);
		xfer(1'b1, rap_pkg::CLEAR_OFF, 32'hF, 32'h0);
		xfer(1'b0, rap_pkg::STAT_OFF, 32'h0, 32'h0);
	endtask
	task t_a2;
		xfer(1'b1, rap_pkg::CTRL_OFF, 32'h8, 32'h0);
		det_in2 <= 3'h2;
		repeat (4) @(posedge clk);
		pk(32'h3);
		xfer(1'b1, rap_pkg::CTRL_OFF, 32'h18, 32'h0);
		pk(32'h2);
		xfer(1'b1, rap_pkg::CTRL_OFF, 32'h10, 32'h0);
		pk(32'h0);
		det_in2 <= 3'h0;
		repeat (4) @(posedge clk);
	endtask
	task t_irq;
		xfer(1'b1, rap_pkg::CLEAR_OFF, 32'hF, 32'h0);
		xfer(1'b1, rap_pkg::ENABLE_OFF, 32'h1, 32'h0);
		xfer(1'b1, rap_pkg::CTRL_OFF, 32'h3, 32'h0);
		pk(32'h8);
		det_in1 <= 3'h2;
		repeat (4) @(posedge clk);
		pk(32'h4C);
		xfer(1'b1, rap_pkg::CTRL_OFF, 32'h1, 32'h0);
		pk(32'h48);
		xfer(1'b1, rap_pkg::ENABLE_OFF, 32'h0, 32'h0);
		pk(32'hC);
		det_in1 <= 3'h0;
		repeat (4) @(posedge clk);
		xfer(1'b1, rap_pkg::ENABLE_OFF, 32'h1, 32'h0);
		pk(32'h48);
		xfer(1'b1, rap_pkg::CLEAR_OFF, 32'h1, 32'h0);
		pk(32'hC);
	endtask
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		s_axi_wstrb = 4'hF;
		{rst_req, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
			s_axi_rready, det_in1, det_in2, s_axi_awaddr, s_axi_araddr,
			s_axi_wdata} = '0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		t_def();
		t_hw();
		t_a1();
		t_a2();
		t_irq();
		end_sim();
	end
endmodule
